/* bench/smi_supply_core_model.sv */
/* far side: supply comparator and a core that records service entries.
   assumes: bench moves warn_level on clock edges; comparator is async. */
`timescale 1ns/10ps
module smi_supply_core_model (
    // clock
    input wire logic aclk,
    // comparator
    input wire logic warn_level,
    output logic aux_voltage_detector,
    // core side
    input wire logic core_enter,
    input wire logic [15:0] irq_vector,
    output int enter_count,
    output logic [15:0] last_vector
);
    // ======================================================================
    // comparator lands off the edge, so the synchroniser is really needed
    initial aux_voltage_detector = 1'b0;
    always @(warn_level) aux_voltage_detector <= #3.7 warn_level;
    // core counts entries and keeps the vector it fetched
    initial enter_count = 0;
    initial last_vector = 16'h0000;
    always @(posedge aclk) begin
        if (core_enter === 1'b1) begin
            enter_count <= enter_count + 1;
            last_vector <= irq_vector;
        end
    end
endmodule

/* bench/smi_top_asserts.sv */
/* port checker for smi_top: bus answers, service entry, mask, reserved bits.
   assumes: one clock, synchronous active-low reset, bound by name. */
`timescale 1ns/10ps
module smi_top_asserts (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // register bus
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // core side
    input wire [15:0] irq_vector,
    input wire core_enter,
    input wire core_masked
);
    // ======================================================================
    // helpers
    logic [11:0] rd_addr_ff;
    logic [11:0] nxt_rd_addr;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // keep the read address so the returned word can be judged
    assign nxt_rd_addr = s_axi_arready ? s_axi_araddr : rd_addr_ff;
    always @(posedge aclk) begin
        if (!aresetn) begin
            rd_addr_ff <= 12'h000;
        end else begin
            rd_addr_ff <= nxt_rd_addr;
        end
    end
    sequence seq_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence seq_entry;
        core_enter ##1 !core_enter;
    endsequence
    // ======================================================================
    // properties
    AST_BVALID_HOLD: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    AST_RVALID_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed");
    AST_R_AFTER_AR: assert property (seq_ar_taken |=> s_axi_rvalid)
        else $error("read answer late");
    AST_RSVD_ZERO: assert property (
        s_axi_rvalid && rd_addr_ff == 12'h000 |-> s_axi_rdata[31:5] == 27'h0)
        else $error("reserved status bits not zero");
    AST_RESET_MASKED: assert property ($rose(aresetn) |-> core_masked)
        else $error("global mask clear after reset");
    AST_ENTER_MASK: assert property (core_enter |-> ##[0:2] core_masked)
        else $error("mask not set at entry");
    AST_ENTER_PULSE: assert property (core_enter |-> seq_entry)
        else $error("entry pulse too long");
    AST_VEC_RANGE: assert property (
        core_enter |-> irq_vector == 16'hfffc || (irq_vector[0] == 1'b0
        && irq_vector >= 16'hffe0 && irq_vector <= 16'hfffa))
        else $error("entry vector out of table");
endmodule
bind smi_top smi_top_asserts u_smi_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq_vector(irq_vector),
    .core_enter(core_enter), .core_masked(core_masked));

/* bench/smi_top_tb.sv */
/* self-checking bench for the supply monitor and interrupt logic.
   assumes: smi_top, its checker and the far-side model are compiled. */
`timescale 1ns/10ps
`include "smi_defs.vh"
module smi_top_tb;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, d;
    logic opt, pll, warn;
    logic [2:0] cause;
    logic [13:0] ev;
    logic [1:0] r;
    wire awready, wready, bvalid, arready, rvalid, aux, irq_req;
    wire wake_wait, wake_halt, core_enter, core_masked;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [15:0] irq_vector, last_vec;
    int enters, i;
    int num_errors = 0;
    int samples_checked = 0;
    // ======================================================================
    // clock, design and far side
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    smi_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .aux_voltage_detector(aux), .low_voltage_detector_opt(opt),
        .pll_locked(pll), .rst_cause_pin(cause[0]), .rst_cause_dog(cause[1]),
        .rst_cause_brownout(cause[2]), .src_event(ev), .irq_req(irq_req),
        .irq_vector(irq_vector), .wake_wait(wake_wait),
        .wake_halt(wake_halt), .core_enter(core_enter),
        .core_masked(core_masked));
    smi_supply_core_model far (.aclk(aclk), .warn_level(warn),
        .aux_voltage_detector(aux), .core_enter(core_enter),
        .irq_vector(irq_vector), .enter_count(enters), .last_vector(last_vec));
    // ======================================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // each channel is released only at the edge that takes it
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [11:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic pulse(input logic [2:0] c, input logic [13:0] e);
        cause <= c;
        ev <= e;
        @(posedge aclk);
        cause <= 3'h0;
        ev <= 14'h0000;
        repeat (3) @(posedge aclk);
    endtask
    // level lands a few cycles late through the synchroniser
    task automatic set_warn(input logic v);
        warn <= v;
        repeat (8) @(posedge aclk);
    endtask
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask
    // instruction end with the mask bit kept, then return
    task automatic serve(input logic m, input logic [15:0] vec);
        int k = enters;
        wr(`SMI_ADDR_CORE, {28'h0, 4'h8} | {31'h0, m});
        for (i = 0; i < 20 && enters == k; i++) @(posedge aclk);
        check(last_vec, vec);
        check(irq_req, 1'b0);
        wr(`SMI_ADDR_CORE, 32'h4);
        check(core_masked, 1'b0);
    endtask
    // ======================================================================
    // scenarios
    task automatic t_regs();
        rd(`SMI_ADDR_STATUS);
        check(d, 32'h0);
        rd(`SMI_ADDR_CORE);
        check(d[0], 1'b1);
        pll <= 1'b1;
        wr(`SMI_ADDR_STATUS, 32'he0);
        check(r, `SMI_RESP_OKAY);
        rd(`SMI_ADDR_STATUS);
        check(d, 32'h08);
        rd(12'h010);
        check(r, `SMI_RESP_SLVERR);
        wr(12'h010, 32'h0);
        check(r, `SMI_RESP_SLVERR);
        set_warn(1'b1);
        rd(`SMI_ADDR_STATUS);
        check(d[1], 1'b0);
        set_warn(1'b0);
    endtask
    task automatic t_causes();
        pulse(3'h2, 14'h0);
        rd(`SMI_ADDR_STATUS);
        check(d, 32'h18);
        wr(`SMI_ADDR_STATUS, 32'h00);
        rd(`SMI_ADDR_STATUS);
        check(d, 32'h08);
        pulse(3'h4, 14'h0);
        pulse(3'h2, 14'h0);
        pulse(3'h1, 14'h0);
        rd(`SMI_ADDR_STATUS);
        check(d, 32'h1c);
        rd(`SMI_ADDR_STATUS);
        check(d, 32'h18);
        pulse(3'h4, 14'h0);
        rd(`SMI_ADDR_STATUS);
        check(d, 32'h0c);
    endtask
    task automatic t_warn();
        wr(`SMI_ADDR_STATUS, 32'h01);
        wr(`SMI_ADDR_CORE, 32'h0);
        set_warn(1'b1);
        rd(`SMI_ADDR_STATUS);
        check(d[1:0], 2'h3);
        check(irq_req, 1'b1);
        serve(1'b0, 16'hffec);
        rd(`SMI_ADDR_PEND);
        check(d[7], 1'b0);
        set_warn(1'b0);
        wr(`SMI_ADDR_STATUS, 32'h02);
        set_warn(1'b1);
        rd(`SMI_ADDR_STATUS);
        check(d[1:0], 2'h2);
        check(irq_req, 1'b0);
        wr(`SMI_ADDR_PEND, 32'h0);
        wr(`SMI_ADDR_STATUS, 32'h01);
        // enable reaches the request output two edges after the write
        @(posedge aclk);
        check(irq_req, 1'b0);
        set_warn(1'b0);
    endtask
    task automatic t_prio();
        wr(`SMI_ADDR_CORE, 32'h1);
        pulse(3'h0, 14'h000c);
        check(irq_req, 1'b0);
        wr(`SMI_ADDR_CORE, 32'h0);
        check(irq_req, 1'b1);
        serve(1'b0, 16'hfff6);
        serve(1'b0, 16'hfff4);
        wr(`SMI_ADDR_CORE, 32'h3);
        check(irq_req, 1'b1);
        serve(1'b1, 16'hfffc);
    endtask
    task automatic t_sleep();
        do_reset();
        wr(`SMI_ADDR_STATUS, 32'h01);
        wr(`SMI_ADDR_CORE, 32'h0);
        wr(`SMI_ADDR_CORE, 32'h10);
        // wake requests stand one cycle, so wait for them to show
        warn <= 1'b1;
        for (i = 0; i < 10 && wake_wait !== 1'b1; i++) @(posedge aclk);
        check(wake_wait, 1'b1);
        rd(`SMI_ADDR_CORE);
        check(d[4], 1'b0);
        set_warn(1'b0);
        do_reset();
        wr(`SMI_ADDR_STATUS, 32'h01);
        wr(`SMI_ADDR_CORE, 32'h21);
        set_warn(1'b1);
        check(wake_halt, 1'b0);
        wr(`SMI_ADDR_STATUS, 32'h00);
        rd(`SMI_ADDR_STATUS);
        check(d[1:0], 2'h1);
        ev <= 14'h0002;
        @(posedge aclk);
        ev <= 14'h0000;
        for (i = 0; i < 10 && wake_halt !== 1'b1; i++) @(posedge aclk);
        check(wake_halt, 1'b1);
    endtask
    // ======================================================================
    // main sequence and watchdog
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata} = 56'h0;
        {opt, pll, warn, cause, ev} = 20'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        opt <= 1'b1;
        do_reset();
        t_causes();
        t_warn();
        t_prio();
        t_sleep();
        stop_test();
    end
    initial begin
        #(20000 * 5);
        num_errors++;
        stop_test();
    end
endmodule

/* hw/smi_sync2.v */
/*
 * two flip-flop level synchroniser.
 * assumes: d_in may change at any time; output is two edges late.
 */
`timescale 1ns/10ps
module smi_sync2 (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // level
    input wire d_in,
    output wire q_out
);

// ==========================================================================
// stages: the first is read only by the second
reg meta_ff;
reg sync_ff;

always @(posedge aclk) begin
    if (!aresetn) begin
        meta_ff <= 1'b0;
        sync_ff <= 1'b0;
    end else begin
        meta_ff <= d_in;
        sync_ff <= meta_ff;
    end
end

assign q_out = sync_ff;

endmodule

/* hw/smi_top.v */
/*
 * supply monitor and interrupt logic: integrity status register, pending
 * latches for fourteen sources, fixed priority, trap, wake from wait/halt.
 * assumes: axi4-lite master on aclk; reset cause pulses and core events
 * are synchronous one-cycle pulses; comparator output is asynchronous.
 */
`timescale 1ns/10ps
`include "smi_defs.vh"
module smi_top (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address and data
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // analogue and option inputs
    input wire aux_voltage_detector,
    input wire low_voltage_detector_opt,
    input wire pll_locked,
    // reset cause pulses from the reset sequencer
    input wire rst_cause_pin,
    input wire rst_cause_dog,
    input wire rst_cause_brownout,
    // other interrupt sources, one bit per source number
    input wire [13:0] src_event,
    // core side
    output reg irq_req,
    output reg [15:0] irq_vector,
    output reg wake_wait,
    output reg wake_halt,
    output reg core_enter,
    output reg core_masked
);

// ==========================================================================
// state
localparam ST_RUN = 3'b001;
localparam ST_ENTER = 3'b010;
localparam ST_SERVE = 3'b100;

reg [2:0] state_ff;
reg [2:0] nxt_state;
reg ie_ff;
reg dog_ff;
reg bor_ff;
reg lock_ff;
reg warn_ff;
reg warn_prev_ff;
reg gmask_ff;
reg wait_ff;
reg halt_ff;
reg trap_req_ff;
reg [13:0] pend_ff;
reg [13:0] srcen_ff;
reg [3:0] sel_ff;
reg sel_trap_ff;
reg have_aw_ff;
reg have_w_ff;
reg [11:0] awaddr_ff;
reg [31:0] wdata_ff;
reg [3:0] wstrb_ff;
wire warn_sync;
wire [7:0] status_val;
wire wr_fire;
wire rd_fire;
reg [3:0] win_idx;
reg win_any;
reg [13:0] pend_set;
integer i;
integer j;

// comparator crossing
smi_sync2 u_warn_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d_in(aux_voltage_detector),
    .q_out(warn_sync)
);

// ==========================================================================
// integrity register image; reserved bits tied low
assign status_val = {3'b000, dog_ff, lock_ff, bor_ff, warn_ff, ie_ff};

assign wr_fire = have_aw_ff && have_w_ff && !s_axi_bvalid;
assign rd_fire = s_axi_arvalid && s_axi_arready;
// core strobes written through the core register
wire core_wr = wr_fire && (awaddr_ff == `SMI_ADDR_CORE) && wstrb_ff[0];
wire core_instr_end = core_wr && wdata_ff[`SMI_BIT_INSTR_END];
wire core_ret = core_wr && wdata_ff[`SMI_BIT_RET];

// ==========================================================================
// fixed priority: trap first, then lowest source number wins
always @* begin
    win_idx = 4'h0;
    win_any = 1'b0;
    for (i = `SMI_NSRC - 1; i >= 0; i = i - 1) begin
        if (pend_ff[i] && srcen_ff[i]) begin
            win_idx = i[3:0];
            win_any = 1'b1;
        end
    end
end

// new events this cycle; warning taken on rising flag with option on
always @* begin
    pend_set = src_event;
    pend_set[`SMI_SRC_WARN] = low_voltage_detector_opt && warn_sync
        && !warn_prev_ff;
end

// ==========================================================================
// servicing sequence
always @* begin
    nxt_state = state_ff;
    case (state_ff)
        ST_RUN: begin
            // only between instructions, and trap ignores the mask
            if (core_instr_end && (trap_req_ff ||
                (win_any && !gmask_ff))) begin
                nxt_state = ST_ENTER;
            end
        end
        ST_ENTER: nxt_state = ST_SERVE;
        ST_SERVE: begin
            if (core_ret) begin
                nxt_state = ST_RUN;
            end
        end
        default: nxt_state = ST_RUN;
    endcase
end

// sequence state, global mask, trap and low power levels
always @(posedge aclk) begin
    if (!aresetn) begin
        state_ff <= ST_RUN;
        gmask_ff <= 1'b1; // all masked after reset
        trap_req_ff <= 1'b0;
        sel_ff <= 4'h0;
        sel_trap_ff <= 1'b0;
        wait_ff <= 1'b0;
        halt_ff <= 1'b0;
    end else begin
        state_ff <= nxt_state;
        if (core_wr && wdata_ff[`SMI_BIT_TRAP]) begin
            trap_req_ff <= 1'b1;
        end
        if (core_wr && wdata_ff[`SMI_BIT_WAIT]) begin
            wait_ff <= 1'b1;
        end
        if (core_wr && wdata_ff[`SMI_BIT_HALT]) begin
            halt_ff <= 1'b1;
        end
        // wake clears the low power level
        if (wait_ff && win_any) begin
            wait_ff <= 1'b0;
        end
        if (halt_ff && |(pend_ff & srcen_ff & `SMI_HALT_WAKE)) begin
            halt_ff <= 1'b0;
        end
        if (state_ff == ST_RUN && nxt_state == ST_ENTER) begin
            sel_trap_ff <= trap_req_ff;
            sel_ff <= win_idx;
            // a trap written with this boundary stays for the next entry
            trap_req_ff <= wdata_ff[`SMI_BIT_TRAP];
            gmask_ff <= 1'b1; // entry masks, no preemption
            wait_ff <= 1'b0;
            halt_ff <= 1'b0;
        end else if (core_ret && state_ff == ST_SERVE) begin
            gmask_ff <= 1'b0;
        end else if (core_wr && state_ff == ST_RUN) begin
            gmask_ff <= wdata_ff[`SMI_BIT_GMASK];
        end
    end
end

// ==========================================================================
// pending latches: set wins over any clear in the same cycle
always @(posedge aclk) begin
    if (!aresetn) begin
        pend_ff <= 14'h0000;
        srcen_ff <= `SMI_EXT_MASK;
    end else begin
        for (j = 0; j < `SMI_NSRC; j = j + 1) begin
            if (pend_set[j] && !(j == `SMI_SRC_WARN && halt_ff)) begin
                pend_ff[j] <= 1'b1;
            end else if (state_ff == ST_ENTER && !sel_trap_ff &&
                sel_ff == j[3:0]) begin
                pend_ff[j] <= 1'b0;
            end else if (wr_fire && awaddr_ff == `SMI_ADDR_PEND &&
                !wdata_ff[j]) begin
                pend_ff[j] <= 1'b0;
            end
        end
        if (wr_fire && awaddr_ff == `SMI_ADDR_SRCEN) begin
            srcen_ff <= wdata_ff[13:0] & ~14'h0080;
        end
        // warning source follows its enable bit and the option input, also during a write
        srcen_ff[`SMI_SRC_WARN] <= ie_ff &&
            low_voltage_detector_opt;
    end
end

// ==========================================================================
// integrity register; frozen while halted, except the reset cause flags
always @(posedge aclk) begin
    if (!aresetn) begin
        ie_ff <= 1'b0;
        dog_ff <= 1'b0;
        bor_ff <= 1'b0;
        lock_ff <= 1'b0;
        warn_ff <= 1'b0;
        warn_prev_ff <= 1'b0;
    end else begin
        warn_prev_ff <= warn_sync;
        if (!halt_ff) begin
            lock_ff <= pll_locked;
            warn_ff <= warn_sync && low_voltage_detector_opt;
            if (wr_fire && awaddr_ff == `SMI_ADDR_STATUS && wstrb_ff[0]) begin
                ie_ff <= wdata_ff[`SMI_BIT_IE];
                if (!wdata_ff[`SMI_BIT_DOG]) begin
                    dog_ff <= 1'b0;
                end
            end
            if (rd_fire && s_axi_araddr == `SMI_ADDR_STATUS) begin
                bor_ff <= 1'b0;
            end
        end
        // reset causes override, also during halt; pin leaves flags
        if (rst_cause_dog) begin
            dog_ff <= 1'b1;
        end
        if (rst_cause_brownout) begin
            bor_ff <= 1'b1;
            dog_ff <= 1'b0;
        end
    end
end

// ==========================================================================
// core outputs, registered
always @(posedge aclk) begin
    if (!aresetn) begin
        irq_req <= 1'b0;
        irq_vector <= 16'h0000;
        wake_wait <= 1'b0;
        wake_halt <= 1'b0;
        core_enter <= 1'b0;
        core_masked <= 1'b1;
    end else begin
        irq_req <= trap_req_ff || (win_any && !gmask_ff);
        core_enter <= (state_ff == ST_ENTER);
        core_masked <= gmask_ff;
        irq_vector <= sel_trap_ff ? `SMI_VEC_TRAP :
            (`SMI_VEC_TOP - {11'h000, sel_ff, 1'b0});
        wake_wait <= wait_ff && win_any;
        wake_halt <= halt_ff && |(pend_ff & srcen_ff & `SMI_HALT_WAKE);
    end
end

// ==========================================================================
// axi4-lite write path: address and data in either order
always @(posedge aclk) begin
    if (!aresetn) begin
        have_aw_ff <= 1'b0;
        have_w_ff <= 1'b0;
        awaddr_ff <= 12'h000;
        wdata_ff <= 32'h0000_0000;
        wstrb_ff <= 4'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `SMI_RESP_OKAY;
    end else begin
        s_axi_awready <= !have_aw_ff && !s_axi_awready && s_axi_awvalid;
        s_axi_wready <= !have_w_ff && !s_axi_wready && s_axi_wvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            have_aw_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            have_w_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end
        if (wr_fire) begin
            have_aw_ff <= 1'b0;
            have_w_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_ff[11:4] == 8'h00) ? `SMI_RESP_OKAY :
                `SMI_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// axi4-lite read path: one cycle after the address is taken
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `SMI_RESP_OKAY;
    end else begin
        s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
        if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `SMI_RESP_OKAY;
            case (s_axi_araddr)
                `SMI_ADDR_STATUS: s_axi_rdata <= {24'h000000, status_val};
                `SMI_ADDR_CORE: s_axi_rdata <= {26'h0000000, halt_ff,
                    wait_ff, 2'b00, trap_req_ff, gmask_ff};
                `SMI_ADDR_PEND: s_axi_rdata <= {18'h00000, pend_ff};
                `SMI_ADDR_SRCEN: s_axi_rdata <= {18'h00000, srcen_ff};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `SMI_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule

/* shared/smi_defs.vh */
/*
 * register map, field positions and constants of the supply monitor and
 * interrupt logic.
 * assumes: included by the design files by bare name, once per file.
 */
`ifndef SMI_DEFS_VH
`define SMI_DEFS_VH

// ==========================================================================
// register byte addresses
`define SMI_ADDR_STATUS 12'h000
`define SMI_ADDR_CORE 12'h004
`define SMI_ADDR_PEND 12'h008
`define SMI_ADDR_SRCEN 12'h00c

// ==========================================================================
// integrity register fields
`define SMI_BIT_IE 0
`define SMI_BIT_WARN 1
`define SMI_BIT_BOR 2
`define SMI_BIT_LOCK 3
`define SMI_BIT_DOG 4
`define SMI_STATUS_RST 8'h00

// ==========================================================================
// core control register fields
`define SMI_BIT_GMASK 0
`define SMI_BIT_TRAP 1
`define SMI_BIT_RET 2
`define SMI_BIT_INSTR_END 3
`define SMI_BIT_WAIT 4
`define SMI_BIT_HALT 5

// ==========================================================================
// interrupt sources
`define SMI_NSRC 14
`define SMI_SRC_WARN 7
`define SMI_HALT_WAKE 14'h101f
`define SMI_EXT_MASK 14'h001e

// vectors
`define SMI_VEC_TRAP 16'hfffc
`define SMI_VEC_TOP 16'hfffa

// axi responses
`define SMI_RESP_OKAY 2'b00
`define SMI_RESP_SLVERR 2'b10

`endif
